// ==== src/irq_entry_core.sv ====
// interrupt acceptance, nested entry sequence and return sequence of the core
`default_nettype none
module irq_entry_core
    import irq_entry_pkg::*;
#(
    parameter int unsigned ENTRY_CYCLES = entry_cycles
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // interrupt controller
    input wire logic irq_valid_i,
    input wire logic [1:0] irq_level_i,
    input wire logic [15:0] irq_vector_i,
    // instruction sequencer
    input wire logic instr_last_i,
    input wire logic [2:0] instr_stack_op_i,
    input wire logic [15:0] instr_word_i,
    input wire logic [15:0] next_pc_i,
    // software writes
    input wire logic ps_write_i,
    input wire logic [15:0] ps_value_i,
    input wire logic sp_load_i,
    input wire logic [15:0] sp_value_i,
    // stack memory read data
    input wire logic [15:0] stack_rdata_i,
    // stack memory read and write port
    output logic stack_we_o,
    output logic stack_re_o,
    output logic [15:0] stack_addr_o,
    output logic [15:0] stack_wdata_o,
    // core state
    output logic [15:0] pc_o,
    output logic [15:0] ps_o,
    output logic [15:0] sp_o,
    output logic irq_accept_o,
    output logic entry_busy_o,
    output logic service_start_o,
    output logic in_service_o
);
    // ****************************************
    // elaboration checks
    // ****************************************
    if (ENTRY_CYCLES < 3 || ENTRY_CYCLES > 15) begin : g_bad_entry
        $error("ENTRY_CYCLES must lie between 3 and 15");
    end

    localparam logic [3:0] entry_last = 4'(ENTRY_CYCLES - 1);
    localparam logic [3:0] push_pc_step = 4'h0;
    localparam logic [3:0] push_ps_step = 4'h1;

    stack_if st ();

    stack_pointer u_sp (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .sp_load_i(sp_load_i),
        .sp_value_i(sp_value_i),
        .st(st)
    );

    core_state_t state_q;
    logic [3:0] step_q;
    logic [15:0] pc_q;
    logic [15:0] ps_q;
    logic [1:0] level_q;
    logic [15:0] vector_q;
    logic [3:0] depth_q;
    logic stack_we_q;
    logic stack_re_q;
    logic [15:0] stack_addr_q;
    logic [15:0] stack_wdata_q;
    logic accept_q;
    logic start_q;
    logic busy_q;
    logic in_service_q;
    logic take;
    logic [1:0] mask;
    logic ie;
    stack_op_t op;

    assign mask = ps_q[ps_mask_hi:ps_mask_lo];
    assign ie = ps_q[ps_ie_pos];
    assign op = stack_op_t'(instr_stack_op_i);

    // ****************************************
    // acceptance
    // ****************************************
    // explicit level 3 test is redundant: 3 never outranks any mask value
    assign take = (state_q == st_run) && instr_last_i
        && irq_valid_i && (irq_level_i != level_none)
        && (irq_level_i < mask) && ie;

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= st_run;
            step_q <= 4'h0;
            level_q <= level_none;
            vector_q <= 16'h0000;
        end else begin
            unique case (state_q)
                st_run: begin
                    if (take) begin
                        state_q <= st_entry;
                        step_q <= 4'h0;
                        level_q <= irq_level_i;
                        vector_q <= irq_vector_i;
                    end else if (instr_last_i && op == op_ret) begin
                        state_q <= st_ret_ps;
                    end
                end
                st_entry: begin
                    if (step_q == entry_last) begin
                        state_q <= st_run;
                    end
                    step_q <= step_q + 4'h1;
                end
                st_ret_ps: state_q <= st_ret_pc;
                st_ret_pc: state_q <= st_run;
            endcase
        end
    end

    // ****************************************
    // stack traffic
    // ****************************************
    // only counter and status are ever written by entry
    // status read leaves with the return itself, so its data stands in st_ret_ps
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_we_q <= 1'b0;
            stack_re_q <= 1'b0;
            stack_addr_q <= sp_reset;
            stack_wdata_q <= 16'h0000;
        end else begin
            stack_we_q <= 1'b0;
            stack_re_q <= 1'b0;
            if (state_q == st_entry && step_q == push_pc_step) begin
                stack_we_q <= 1'b1;
                stack_addr_q <= st.sp - 16'h0001;
                stack_wdata_q <= pc_q;
            end else if (state_q == st_entry && step_q == push_ps_step) begin
                stack_we_q <= 1'b1;
                stack_addr_q <= st.sp - 16'h0001;
                stack_wdata_q <= ps_q;
            end else if (state_q == st_run && instr_last_i && !take
                && (op == op_push || op == op_call)) begin
                stack_we_q <= 1'b1;
                stack_addr_q <= st.sp - 16'h0001;
                stack_wdata_q <= (op == op_call) ? next_pc_i : instr_word_i;
            end else if (state_q == st_ret_ps
                || (state_q == st_run && instr_last_i && !take && (op == op_pop || op == op_ret))) begin
                stack_re_q <= 1'b1;
                stack_addr_q <= st.sp;
            end
        end
    end

    // pointer moves in the same cycle the access is issued
    always_comb begin
        st.push = 1'b0;
        st.pop = 1'b0;
        if (state_q == st_entry && (step_q == push_pc_step || step_q == push_ps_step)) begin
            st.push = 1'b1;
        end else if (state_q == st_run && instr_last_i && !take && (op == op_push || op == op_call)) begin
            st.push = 1'b1;
        end else if (state_q == st_ret_ps
            || (state_q == st_run && instr_last_i && !take && (op == op_pop || op == op_ret))) begin
            st.pop = 1'b1;
        end
    end

    // ****************************************
    // counter and status
    // ****************************************
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_q <= pc_reset;
        end else if (state_q == st_entry && step_q == entry_last) begin
            pc_q <= vector_q;
        end else if (state_q == st_ret_pc) begin
            pc_q <= stack_rdata_i;
        end else if (state_q == st_run && instr_last_i) begin
            // ending instruction retires even when a request wins, so the saved counter is the next one
            pc_q <= next_pc_i;
        end
    end

    // status read data stands in st_ret_ps, counter read data one cycle later in st_ret_pc
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ps_q <= ps_reset | ps_mask_reset;
        end else if (state_q == st_entry && step_q == entry_last) begin
            ps_q[ps_mask_hi:ps_mask_lo] <= level_q;
        end else if (state_q == st_ret_ps) begin
            ps_q <= stack_rdata_i;
        end else if (ps_write_i) begin
            ps_q <= ps_value_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            depth_q <= 4'h0;
            in_service_q <= 1'b0;
        end else if (state_q == st_entry && step_q == entry_last && depth_q != 4'hf) begin
            depth_q <= depth_q + 4'h1;
            in_service_q <= 1'b1;
        end else if (state_q == st_ret_pc && depth_q != 4'h0) begin
            depth_q <= depth_q - 4'h1;
            in_service_q <= (depth_q != 4'h1);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            accept_q <= 1'b0;
            start_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            accept_q <= take;
            // mirrors st_entry cycle for cycle, decoded one cycle ahead so the output comes from a flop
            busy_q <= take || (state_q == st_entry && step_q != entry_last);
            start_q <= (state_q == st_entry && step_q == entry_last);
        end
    end

    assign stack_we_o = stack_we_q;
    assign stack_re_o = stack_re_q;
    assign stack_addr_o = stack_addr_q;
    assign stack_wdata_o = stack_wdata_q;
    assign pc_o = pc_q;
    assign ps_o = ps_q;
    assign sp_o = st.sp;
    assign irq_accept_o = accept_q;
    assign entry_busy_o = busy_q;
    assign service_start_o = start_q;
    assign in_service_o = in_service_q;
endmodule // irq_entry_core
`default_nettype wire

// ==== src/irq_entry_pkg.sv ====
// constants and types shared by the interrupt entry and nesting logic
`default_nettype none
package irq_entry_pkg;
    localparam int unsigned clk_freq_hz = 10_000_000;
    localparam int unsigned entry_cycles = 9;
    localparam int unsigned longest_instr_cycles = 17;
    localparam int unsigned worst_latency_cycles = longest_instr_cycles + entry_cycles;
    localparam logic [1:0] level_highest = 2'h0;
    localparam logic [1:0] level_none = 2'h3;
    localparam logic [15:0] sp_reset = 16'h0000;
    localparam logic [15:0] pc_reset = 16'h0000;
    localparam logic [15:0] ps_reset = 16'h0000;
    localparam int unsigned ps_ie_pos = 5;
    localparam int unsigned ps_mask_lo = 3;
    localparam int unsigned ps_mask_hi = 4;
    localparam logic [15:0] ps_mask_reset = {11'h000, level_none, 3'h0};

    typedef enum logic [2:0] {
        op_none,
        op_push,
        op_pop,
        op_call,
        op_ret
    } stack_op_t;

    typedef enum {
        st_run,
        st_entry,
        st_ret_ps,
        st_ret_pc
    } core_state_t;
endpackage : irq_entry_pkg
`default_nettype wire

// ==== src/stack_if.sv ====
// stack memory access signals between the sequencer and the stack pointer
`default_nettype none
interface stack_if;
    logic push;
    logic pop;
    logic [15:0] sp;
    modport ctrl (output push, output pop, input sp);
    modport ptr (input push, input pop, output sp);
endinterface : stack_if
`default_nettype wire

// ==== src/stack_pointer.sv ====
// descending stack pointer, one word per access
`default_nettype none
module stack_pointer
    import irq_entry_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // software load
    input wire logic sp_load_i,
    input wire logic [15:0] sp_value_i,
    // stack requests
    stack_if.ptr st
);
    logic [15:0] sp_q;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sp_q <= sp_reset;
        end else if (sp_load_i) begin
            sp_q <= sp_value_i;
        end else if (st.push) begin
            sp_q <= sp_q - 16'h0001;
        end else if (st.pop) begin
            sp_q <= sp_q + 16'h0001;
        end
    end

    assign st.sp = sp_q;
endmodule // stack_pointer
`default_nettype wire

// ==== tb/irq_ctrl_model.sv ====
// interrupt controller model presenting one pending request level
`default_nettype none
module irq_ctrl_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // bench side
    input wire logic req_i,
    input wire logic [1:0] level_i,
    input wire logic [15:0] vector_i,
    // core side
    input wire logic accept_i,
    output logic irq_valid_o,
    output logic [1:0] irq_level_o,
    output logic [15:0] irq_vector_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // withdrawn request shows no level and a vector that toggles between the stale one and its inverse each cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_valid_o <= 1'b0;
            irq_level_o <= 2'h3;
            irq_vector_o <= 16'h0000;
        end else begin
            irq_valid_o <= req_i && !accept_i;
            irq_level_o <= req_i ? level_i : 2'h3;
            irq_vector_o <= req_i ? vector_i : ~irq_vector_o;
        end
    end
endmodule // irq_ctrl_model
`default_nettype wire

// ==== tb/irq_entry_core_checker.sv ====
// concurrent checks on the interrupt entry core ports
`default_nettype none
module irq_entry_core_checker (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [1:0] irq_level_i,
    input wire logic [15:0] irq_vector_i,
    input wire logic instr_last_i,
    input wire logic [2:0] instr_stack_op_i,
    input wire logic stack_we_o,
    input wire logic stack_re_o,
    input wire logic [15:0] stack_addr_o,
    input wire logic [15:0] pc_o,
    input wire logic [15:0] ps_o,
    input wire logic [15:0] sp_o,
    input wire logic irq_accept_o,
    input wire logic entry_busy_o,
    input wire logic service_start_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_sampled_last_cycle: assert property (irq_accept_o |-> $past(instr_last_i) && $past(ps_o[5]))
        else $error("accept without last cycle or enable");
    a_level3_ignored: assert property (irq_accept_o |-> $past(irq_level_i) != 2'h3)
        else $error("level 3 request accepted");
    a_outranks_mask: assert property (irq_accept_o |-> $past(irq_level_i) < $past(ps_o[4:3]))
        else $error("accepted level does not outrank mask");
    a_nesting_blocked: assert property (instr_last_i && (!ps_o[5] || ps_o[4:3] == 2'h0) |=> !irq_accept_o)
        else $error("accept while blocked");
    a_entry_nine: assert property (irq_accept_o |-> entry_busy_o[*8] ##1 entry_busy_o ##1
        (service_start_o && !entry_busy_o))
        else $error("entry length wrong");
    a_vector_loaded: assert property (service_start_o |-> pc_o == $past(irq_vector_i, 10))
        else $error("counter not loaded from vector");
    a_mask_set: assert property (service_start_o |-> ps_o[4:3] == $past(irq_level_i, 10))
        else $error("mask not set to accepted level");
    a_push_order: assert property (irq_accept_o |-> ##1
        (stack_we_o && stack_addr_o == $past(sp_o, 2) - 16'h0001)
        ##1 (stack_we_o && stack_addr_o == $past(sp_o, 3) - 16'h0002))
        else $error("entry push order or direction wrong");
    a_return_pops: assert property ((instr_last_i && instr_stack_op_i == 3'h4) ##1 !irq_accept_o |->
        (stack_re_o && stack_addr_o == $past(sp_o)) ##1 (stack_re_o && stack_addr_o == $past(sp_o, 2) + 16'h0001))
        else $error("return pop order or direction wrong");
    c_accept: cover property (irq_accept_o);
    c_nested: cover property (service_start_o && ps_o[4:3] == 2'h1);
    c_push: cover property (stack_we_o);
endmodule // irq_entry_core_checker
bind irq_entry_core irq_entry_core_checker i_irq_entry_core_checker (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .irq_level_i(irq_level_i), .irq_vector_i(irq_vector_i), .instr_last_i(instr_last_i),
    .instr_stack_op_i(instr_stack_op_i), .stack_we_o(stack_we_o), .stack_re_o(stack_re_o),
    .stack_addr_o(stack_addr_o), .pc_o(pc_o), .ps_o(ps_o), .sp_o(sp_o),
    .irq_accept_o(irq_accept_o), .entry_busy_o(entry_busy_o), .service_start_o(service_start_o));
`default_nettype wire

// ==== tb/cpu_interrupt_entry_nesting_tb.sv ====
// testbench for interrupt entry, nesting and return
`default_nettype none
module cpu_interrupt_entry_nesting_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, rst_n_i, req, valid, last, ps_write, sp_load, we, re, accept, busy, start, insvc;
    logic [1:0] level, irq_level;
    logic [2:0] op;
    logic [15:0] vector, irq_vector, npc, ps_value, sp_value, rdata, addr, wdata, pc, ps, sp, word;
    logic [15:0] mem [0:511];
    int miscompares = 0;
    int checks = 0;
    irq_ctrl_model i_irq_ctrl_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req), .level_i(level),
        .vector_i(vector), .accept_i(accept), .irq_valid_o(valid), .irq_level_o(irq_level),
        .irq_vector_o(irq_vector));
    irq_entry_core i_irq_entry_core (.clock_i(clock_i), .rst_n_i(rst_n_i), .irq_valid_i(valid),
        .irq_level_i(irq_level), .irq_vector_i(irq_vector), .instr_last_i(last), .instr_stack_op_i(op),
        .instr_word_i(word), .next_pc_i(npc), .ps_write_i(ps_write), .ps_value_i(ps_value),
        .sp_load_i(sp_load), .sp_value_i(sp_value), .stack_rdata_i(rdata), .stack_we_o(we), .stack_re_o(re),
        .stack_addr_o(addr), .stack_wdata_o(wdata), .pc_o(pc), .ps_o(ps), .sp_o(sp), .irq_accept_o(accept),
        .entry_busy_o(busy), .service_start_o(start), .in_service_o(insvc));
    // stack memory, read data combinational at the addressed word
    always @(posedge clock_i) if (we) mem[addr[8:0]] <= wdata;
    assign rdata = mem[addr[8:0]];
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_instr(input logic [2:0] kind, input logic [15:0] next);
        last = 1'b1;
        op = kind;
        npc = next;
        tick(1);
        last = 1'b0;
        op = 3'h0;
    endtask
    task automatic write_ps(input logic [15:0] v);
        ps_write = 1'b1;
        ps_value = v;
        tick(1);
        ps_write = 1'b0;
    endtask
    // raise a request, stall mid-instruction, then end the instruction
    task automatic enter(input logic [1:0] lvl, input logic [15:0] vec, input logic [15:0] next, input logic take);
        int n;
        req = 1'b1;
        level = lvl;
        vector = vec;
        repeat (4) begin
            tick(1);
            check("early accept", 16'h0000, {15'h0000, accept});
        end
        end_instr(3'h0, next);
        req = 1'b0;
        check("accept", {15'h0000, take}, {15'h0000, accept});
        n = 0;
        while (take && start !== 1'b1 && n < 30) begin
            tick(1);
            n++;
        end
        if (take) check("entry cycles", 16'h0009, n[15:0]);
        tick(1);
    endtask
    task automatic ret(input logic [15:0] epc, input logic [15:0] eps, input logic [15:0] esp);
        end_instr(3'h4, 16'h0000);
        tick(4);
        check("ps after return", eps, ps);
        check("pc after return", epc, pc);
        check("sp after return", esp, sp);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clock_i);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {rst_n_i, req, last, ps_write, sp_load, level, op} = '0;
        {vector, npc, ps_value, sp_value, word} = '0;
        tick(3);
        rst_n_i = 1'b1;
        check("ps at reset", 16'h0018, ps);
        check("sp at reset", 16'h0000, sp);
        sp_load = 1'b1;
        sp_value = 16'h0100;
        tick(1);
        sp_load = 1'b0;
        $display("test reset done");
        enter(2'h2, 16'h2000, 16'h1111, 1'b0);
        write_ps(16'h0038);
        enter(2'h3, 16'h2000, 16'h1111, 1'b0);
        enter(2'h2, 16'h2000, 16'h1234, 1'b1);
        check("pc vector", 16'h2000, pc);
        check("ps mask 2", 16'h0030, ps);
        check("pushed pc", 16'h1234, mem[9'h0ff]);
        check("pushed ps", 16'h0038, mem[9'h0fe]);
        check("sp entry", 16'h00fe, sp);
        check("in service", 16'h0001, {15'h0000, insvc});
        $display("test first entry done");
        enter(2'h2, 16'h3000, 16'h2222, 1'b0);
        enter(2'h1, 16'h3000, 16'h2222, 1'b1);
        check("pc nested", 16'h3000, pc);
        check("ps mask 1", 16'h0028, ps);
        check("nested ps", 16'h0030, mem[9'h0fc]);
        write_ps(16'h0020);
        enter(2'h0, 16'h4000, 16'h3333, 1'b0);
        $display("test nesting done");
        ret(16'h2222, 16'h0030, 16'h00fe);
        ret(16'h1234, 16'h0038, 16'h0100);
        check("out of service", 16'h0000, {15'h0000, insvc});
        end_instr(3'h3, 16'h5555);
        tick(2);
        check("call push", 16'h5555, mem[9'h0ff]);
        check("sp call", 16'h00ff, sp);
        $display("test return and call done");
        word = 16'h00a5;
        end_instr(3'h1, 16'h5556);
        tick(1);
        check("word push", 16'h00a5, mem[9'h0fe]);
        end_instr(3'h2, 16'h5557);
        check("pop strobe", 16'h0001, {15'h0000, re});
        check("pop addr", 16'h00fe, addr);
        tick(1);
        check("sp pop", 16'h00ff, sp);
        $display("test word push and pop done");
        tally_and_finish();
    end
endmodule // cpu_interrupt_entry_nesting_tb
`default_nettype wire
